/* hdl/fdx_pkg.sv */
package fdx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_RESULT = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_MAIN_STAT = 5'h0C;
  localparam logic [4:0] OFS_CONTROL = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

  // main status field positions
  localparam int MS_RQM = 7;
  localparam int MS_DIO = 6;
  localparam int MS_BUSY = 4;

  // control and interrupt field positions
  localparam int CTL_XFER_END = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DREQ = 1;
  localparam int IRQ_W = 2;

  // first command byte opcodes
  localparam logic [5:0] OP_WR_DELETED = 6'h09;
  localparam logic [4:0] OP_RD_DELETED = 5'h0C;
  localparam logic [4:0] OP_RD_TRACK = 5'h02;
  localparam int OP_XHEAD = 7;
  localparam int OP_DENSITY = 6;
  localparam int OP_BYPASS = 5;

  // command and result lengths
  localparam logic [3:0] CMD_LAST_IDX = 4'h8;
  localparam logic [2:0] RES_LAST_IDX = 3'h6;

  // status byte fields
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  localparam int ST1_END_CYL = 7;
  localparam int ST1_DATA_ERR = 5;
  localparam int ST1_OVERRUN = 4;
  localparam int ST1_ID_MISMATCH = 2;
  localparam int ST1_ABSENT_ID = 0;
  localparam int ST2_CONTROL_MARK = 6;

  // sector length base for size code zero
  localparam logic [14:0] SECT_BASE_LEN = 15'h0080;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // write byte service limits
  localparam int CLK_KHZ = 40000;
  localparam int FM_BYTE_US = 27;
  localparam int MFM_BYTE_US = 13;
  localparam int FM_BYTE_CYC = FM_BYTE_US * CLK_KHZ / 1000;
  localparam int MFM_BYTE_CYC = MFM_BYTE_US * CLK_KHZ / 1000;
  localparam int TMR_W = 11;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_SEEK, S_WR, S_MARK, S_RD, S_TRK_WAIT, S_TRK, S_RES
  } fdx_state_t;

endpackage

/* hdl/fdx_byte_timer.sv */
`timescale 1ns/1ps
module fdx_byte_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [fdx_pkg::TMR_W-1:0] limit_i,
  output logic expired_o
);

  logic [fdx_pkg::TMR_W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // counts while waiting, pulses once at the limit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      expired_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= '0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= (cnt_reg == limit_i - 1'b1);
      if (cnt_reg != limit_i) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

/* hdl/fdx_cmd_exec.sv */
`timescale 1ns/1ps
// How it works
// - write deleted writes deleted mark, else write
// - ordinary mark, no bypass: read sector, flag, stop
// - ordinary mark with bypass: skip to next
// - track read starts at index, streams fields
// - track read ends at last sector count
// - track read never switches heads
// - CRC errors never stop track read
// - track ID mismatch sets no-data flag
// - no ID by second index: absent flag on track read, no-data flag on other commands
// - seven result bytes after each valid command, one after an invalid opcode
// - write starts only on full ID match
// - sectors advance to last, end-of-cylinder
// - transfer end mid-sector pads with zeros
// - late write byte aborts with overrun
module fdx_cmd_exec (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic IRQ_O,
  input wire logic INDEX_I,
  input wire logic FLD_ID_VALID_I,
  input wire logic [7:0] FLD_ID_TRACK_I,
  input wire logic [7:0] FLD_ID_HEAD_I,
  input wire logic [7:0] FLD_ID_SECTOR_I,
  input wire logic [7:0] FLD_ID_SIZE_I,
  input wire logic FLD_ID_CRC_ERR_I,
  input wire logic FLD_MARK_VALID_I,
  input wire logic FLD_MARK_DELETED_I,
  input wire logic FLD_BYTE_VALID_I,
  input wire logic [7:0] FLD_BYTE_I,
  input wire logic FLD_DATA_END_I,
  input wire logic WR_REQ_I,
  output logic WR_START_O,
  output logic WR_DELETED_MARK_O,
  output logic [7:0] WR_BYTE_O,
  output logic WR_BYTE_VALID_O,
  output logic HEAD_SEL_O,
  output logic [1:0] DRIVE_SEL_O,
  output logic DENSITY_O
);

  fdx_pkg::fdx_state_t state_reg;
  logic [3:0] cmd_idx_reg;
  logic [2:0] res_idx_reg, res_last_reg;
  logic [7:0] op_reg, trk_reg, hd_reg, sec_reg, sz_reg, eot_reg;
  logic [7:0] st0_reg, st1_reg, st2_reg, sec_cnt_reg;
  logic is_write_reg, is_track_reg, bypass_reg, cross_head_reg;
  logic last_sect_reg, skip_sect_reg, id_seen_reg, idx_seen_reg;
  logic xfer_end_reg, pad_reg, pend_reg, wr_full_reg, rd_full_reg;
  logic [7:0] wr_buf_reg, rd_buf_reg;
  logic [14:0] byte_cnt_reg, sect_len;
  logic [fdx_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic idx_s1_reg, idx_s2_reg, idx_s3_reg, idx_edge;
  logic wait_reg, rd_start, wr_acc, wr_send, rd_push, timeout, id_match;
  logic [7:0] ms_byte, res_byte;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // index pin synchroniser and edge detect
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      idx_s1_reg <= 1'b0;
      idx_s2_reg <= 1'b0;
      idx_s3_reg <= 1'b0;
    end else begin
      idx_s1_reg <= INDEX_I;
      idx_s2_reg <= idx_s1_reg;
      idx_s3_reg <= idx_s2_reg;
    end
  end
  assign idx_edge = idx_s2_reg & ~idx_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait state; reads act on the first edge, writes on the taken edge
  assign rd_start = AVS_READ_I & wait_reg;
  assign wr_acc = AVS_WRITE_I & ~wait_reg;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wait_reg <= 1'b1;
      AVS_READDATA_O <= '0;
    end else begin
      wait_reg <= ~((AVS_READ_I | AVS_WRITE_I) & wait_reg);
      if (rd_start) begin
        AVS_READDATA_O <= rd_mux;
      end
    end
  end
  assign AVS_WAITREQUEST_O = wait_reg;

  // result byte selection
  always_comb begin
    case (res_idx_reg)
      3'h0: res_byte = st0_reg;
      3'h1: res_byte = st1_reg;
      3'h2: res_byte = st2_reg;
      3'h3: res_byte = trk_reg;
      3'h4: res_byte = hd_reg;
      3'h5: res_byte = sec_reg;
      3'h6: res_byte = sz_reg;
      default: res_byte = fdx_pkg::BYTE_RST;
    endcase
  end

  // main status and read mux; unmapped reads return zero
  always_comb begin
    ms_byte = fdx_pkg::BYTE_RST;
    ms_byte[fdx_pkg::MS_BUSY] = (state_reg != fdx_pkg::S_IDLE);
    ms_byte[fdx_pkg::MS_DIO] = (state_reg == fdx_pkg::S_RES) | rd_full_reg;
    case (state_reg)
      fdx_pkg::S_IDLE, fdx_pkg::S_CMD, fdx_pkg::S_RES:
        ms_byte[fdx_pkg::MS_RQM] = 1'b1;
      fdx_pkg::S_WR: ms_byte[fdx_pkg::MS_RQM] = ~wr_full_reg;
      default: ms_byte[fdx_pkg::MS_RQM] = rd_full_reg;
    endcase
    case (AVS_ADDRESS_I)
      fdx_pkg::OFS_RESULT: rd_mux = {24'h000000,
        (state_reg == fdx_pkg::S_RES) ? res_byte : fdx_pkg::BYTE_RST};
      fdx_pkg::OFS_DATA: rd_mux = {24'h000000, rd_buf_reg};
      fdx_pkg::OFS_MAIN_STAT: rd_mux = {24'h000000, ms_byte};
      fdx_pkg::OFS_CONTROL: rd_mux = {31'h00000000, xfer_end_reg};
      fdx_pkg::OFS_IRQ_STAT: rd_mux = {30'h00000000, irq_stat_reg};
      fdx_pkg::OFS_IRQ_MASK: rd_mux = {30'h00000000, irq_mask_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, set wins over write-one-clear
  assign irq_set[fdx_pkg::IRQ_DONE] = 1'b0;
  assign irq_set[fdx_pkg::IRQ_DREQ] = rd_push |
    (WR_REQ_I & (state_reg == fdx_pkg::S_WR));
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      irq_stat_reg <= fdx_pkg::IRQ_RST;
      irq_mask_reg <= fdx_pkg::IRQ_RST;
      IRQ_O <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_acc &
        (AVS_ADDRESS_I == fdx_pkg::OFS_IRQ_STAT)) ?
        AVS_WRITEDATA_I[fdx_pkg::IRQ_W-1:0] : fdx_pkg::IRQ_RST)) | irq_set |
        {1'b0, (state_reg != fdx_pkg::S_RES) &&
               (state_reg != fdx_pkg::S_IDLE) && (state_reg != fdx_pkg::S_CMD)
               && 1'b0};
      if (wr_acc && AVS_ADDRESS_I == fdx_pkg::OFS_IRQ_MASK) begin
        irq_mask_reg <= AVS_WRITEDATA_I[fdx_pkg::IRQ_W-1:0];
      end
      IRQ_O <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read byte holding buffer towards the host
  assign rd_push = FLD_BYTE_VALID_I & ~skip_sect_reg &
    ((state_reg == fdx_pkg::S_RD) | (state_reg == fdx_pkg::S_TRK));
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rd_full_reg <= 1'b0;
      rd_buf_reg <= fdx_pkg::BYTE_RST;
    end else if (rd_push) begin
      rd_full_reg <= 1'b1;
      rd_buf_reg <= FLD_BYTE_I;
    end else if (rd_start && AVS_ADDRESS_I == fdx_pkg::OFS_DATA) begin
      rd_full_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write byte path to the disk; zero fill once transfer end is seen
  assign wr_send = pend_reg & (pad_reg | wr_full_reg) &
    (state_reg == fdx_pkg::S_WR);
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      pend_reg <= 1'b0;
      wr_full_reg <= 1'b0;
      wr_buf_reg <= fdx_pkg::BYTE_RST;
      WR_BYTE_O <= fdx_pkg::BYTE_RST;
      WR_BYTE_VALID_O <= 1'b0;
    end else begin
      WR_BYTE_VALID_O <= wr_send;
      if (wr_send) begin
        WR_BYTE_O <= pad_reg ? fdx_pkg::BYTE_RST : wr_buf_reg;
      end
      if (state_reg != fdx_pkg::S_WR) begin
        pend_reg <= 1'b0;
      end else if (WR_REQ_I) begin
        pend_reg <= 1'b1;
      end else if (wr_send) begin
        pend_reg <= 1'b0;
      end
      if (wr_acc && AVS_ADDRESS_I == fdx_pkg::OFS_DATA) begin
        wr_full_reg <= 1'b1;
        wr_buf_reg <= AVS_WRITEDATA_I[7:0];
      end else if (wr_send && !pad_reg) begin
        wr_full_reg <= 1'b0;
      end
    end
  end

  // late host byte watchdog, limit follows density
  fdx_byte_timer u_timer (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .run_i(pend_reg & ~pad_reg & ~wr_full_reg &
           (state_reg == fdx_pkg::S_WR)),
    .limit_i(DENSITY_O ? fdx_pkg::TMR_W'(fdx_pkg::MFM_BYTE_CYC) :
             fdx_pkg::TMR_W'(fdx_pkg::FM_BYTE_CYC)),
    .expired_o(timeout)
  );

  assign sect_len = fdx_pkg::SECT_BASE_LEN << sz_reg[2:0];
  assign id_match = (FLD_ID_TRACK_I == trk_reg) && (FLD_ID_HEAD_I == hd_reg)
    && (FLD_ID_SECTOR_I == sec_reg) && (FLD_ID_SIZE_I == sz_reg);

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state_reg <= fdx_pkg::S_IDLE;
      {cmd_idx_reg, res_idx_reg, res_last_reg} <= '0;
      {op_reg, trk_reg, hd_reg, sec_reg, sz_reg, eot_reg} <= '0;
      {st0_reg, st1_reg, st2_reg, sec_cnt_reg, byte_cnt_reg} <= '0;
      {is_write_reg, is_track_reg, bypass_reg, cross_head_reg} <= '0;
      {last_sect_reg, skip_sect_reg, id_seen_reg, idx_seen_reg} <= '0;
      {xfer_end_reg, pad_reg, WR_START_O, WR_DELETED_MARK_O} <= '0;
      {HEAD_SEL_O, DRIVE_SEL_O, DENSITY_O} <= '0;
    end else begin
      WR_START_O <= 1'b0;
      if (wr_acc && AVS_ADDRESS_I == fdx_pkg::OFS_CONTROL &&
          AVS_WRITEDATA_I[fdx_pkg::CTL_XFER_END]) begin
        xfer_end_reg <= 1'b1;
      end
      if (state_reg == fdx_pkg::S_WR && xfer_end_reg) begin
        pad_reg <= 1'b1;
      end
      case (state_reg)
        fdx_pkg::S_IDLE, fdx_pkg::S_CMD: begin
          if (wr_acc && AVS_ADDRESS_I == fdx_pkg::OFS_CMD) begin
            state_reg <= fdx_pkg::S_CMD;
            cmd_idx_reg <= cmd_idx_reg + 4'h1;
            case (cmd_idx_reg)
              4'h0: op_reg <= AVS_WRITEDATA_I[7:0];
              4'h1: begin
                HEAD_SEL_O <= AVS_WRITEDATA_I[2];
                DRIVE_SEL_O <= AVS_WRITEDATA_I[1:0];
              end
              4'h2: trk_reg <= AVS_WRITEDATA_I[7:0];
              4'h3: hd_reg <= AVS_WRITEDATA_I[7:0];
              4'h4: sec_reg <= AVS_WRITEDATA_I[7:0];
              4'h5: sz_reg <= AVS_WRITEDATA_I[7:0];
              4'h6: eot_reg <= AVS_WRITEDATA_I[7:0];
              default: ;
            endcase
            if (cmd_idx_reg == 4'h0 &&
                AVS_WRITEDATA_I[5:0] != fdx_pkg::OP_WR_DELETED &&
                AVS_WRITEDATA_I[4:0] != fdx_pkg::OP_RD_DELETED &&
                AVS_WRITEDATA_I[4:0] != fdx_pkg::OP_RD_TRACK) begin
              st0_reg <= fdx_pkg::ST0_INVALID;
              res_last_reg <= 3'h0;
              res_idx_reg <= 3'h0;
              cmd_idx_reg <= 4'h0;
              state_reg <= fdx_pkg::S_RES;
            end else if (cmd_idx_reg == fdx_pkg::CMD_LAST_IDX) begin
              cmd_idx_reg <= 4'h0;
              is_write_reg <= (op_reg[5:0] == fdx_pkg::OP_WR_DELETED);
              WR_DELETED_MARK_O <= (op_reg[5:0] == fdx_pkg::OP_WR_DELETED);
              is_track_reg <= (op_reg[4:0] == fdx_pkg::OP_RD_TRACK);
              bypass_reg <= op_reg[fdx_pkg::OP_BYPASS] &
                (op_reg[5:0] != fdx_pkg::OP_WR_DELETED);
              cross_head_reg <= op_reg[fdx_pkg::OP_XHEAD] &
                (op_reg[4:0] != fdx_pkg::OP_RD_TRACK);
              DENSITY_O <= op_reg[fdx_pkg::OP_DENSITY];
              {st0_reg, st1_reg, st2_reg, sec_cnt_reg} <= '0;
              {last_sect_reg, skip_sect_reg, id_seen_reg} <= '0;
              {idx_seen_reg, xfer_end_reg, pad_reg} <= '0;
              res_last_reg <= fdx_pkg::RES_LAST_IDX;
              state_reg <= (op_reg[4:0] == fdx_pkg::OP_RD_TRACK) ?
                fdx_pkg::S_TRK_WAIT : fdx_pkg::S_SEEK;
            end
          end
        end
        fdx_pkg::S_SEEK: begin
          if (FLD_ID_VALID_I && FLD_ID_CRC_ERR_I) begin
            st1_reg[fdx_pkg::ST1_DATA_ERR] <= 1'b1;
            st0_reg[7:6] <= fdx_pkg::TERM_ABNORMAL;
            state_reg <= fdx_pkg::S_RES;
          end else if (FLD_ID_VALID_I && id_match) begin
            idx_seen_reg <= 1'b0;
            byte_cnt_reg <= '0;
            WR_START_O <= is_write_reg;
            state_reg <= is_write_reg ? fdx_pkg::S_WR : fdx_pkg::S_MARK;
          end else if (idx_edge && idx_seen_reg) begin
            st1_reg[fdx_pkg::ST1_ID_MISMATCH] <= 1'b1;
            st0_reg[7:6] <= fdx_pkg::TERM_ABNORMAL;
            state_reg <= fdx_pkg::S_RES;
          end else if (idx_edge) begin
            idx_seen_reg <= 1'b1;
          end
        end
        fdx_pkg::S_MARK: begin
          if (FLD_MARK_VALID_I) begin
            state_reg <= fdx_pkg::S_RD;
            if (!FLD_MARK_DELETED_I && bypass_reg) begin
              skip_sect_reg <= 1'b1;
            end else if (!FLD_MARK_DELETED_I) begin
              st2_reg[fdx_pkg::ST2_CONTROL_MARK] <= 1'b1;
              last_sect_reg <= 1'b1;
            end
          end
        end
        fdx_pkg::S_RD, fdx_pkg::S_WR: begin
          if (rd_push && rd_full_reg || timeout) begin
            st1_reg[fdx_pkg::ST1_OVERRUN] <= 1'b1;
            st0_reg[7:6] <= fdx_pkg::TERM_ABNORMAL;
            state_reg <= fdx_pkg::S_RES;
          end else if ((state_reg == fdx_pkg::S_RD) ? FLD_DATA_END_I :
                       (wr_send && byte_cnt_reg == sect_len - 15'h0001)) begin
            skip_sect_reg <= 1'b0;
            if (last_sect_reg || xfer_end_reg) begin
              st0_reg[7:6] <= fdx_pkg::TERM_NORMAL;
              state_reg <= fdx_pkg::S_RES;
            end else if (sec_reg != eot_reg) begin
              sec_reg <= sec_reg + 8'h01;
              state_reg <= fdx_pkg::S_SEEK;
            end else if (cross_head_reg && !hd_reg[0]) begin
              hd_reg[0] <= 1'b1;
              HEAD_SEL_O <= 1'b1;
              sec_reg <= 8'h01;
              state_reg <= fdx_pkg::S_SEEK;
            end else begin
              trk_reg <= trk_reg + 8'h01;
              hd_reg[0] <= hd_reg[0] ^ cross_head_reg;
              sec_reg <= 8'h01;
              st1_reg[fdx_pkg::ST1_END_CYL] <= 1'b1;
              st0_reg[7:6] <= fdx_pkg::TERM_ABNORMAL;
              state_reg <= fdx_pkg::S_RES;
            end
          end else if (wr_send) begin
            byte_cnt_reg <= byte_cnt_reg + 15'h0001;
          end
        end
        fdx_pkg::S_TRK_WAIT: begin
          if (idx_edge) begin
            state_reg <= fdx_pkg::S_TRK;
          end
        end
        fdx_pkg::S_TRK: begin
          if (FLD_ID_VALID_I) begin
            id_seen_reg <= 1'b1;
            if (!id_match) begin
              st1_reg[fdx_pkg::ST1_ID_MISMATCH] <= 1'b1;
            end
          end
          if (rd_push && rd_full_reg) begin
            st1_reg[fdx_pkg::ST1_OVERRUN] <= 1'b1;
            st0_reg[7:6] <= fdx_pkg::TERM_ABNORMAL;
            state_reg <= fdx_pkg::S_RES;
          end else if (idx_edge && !id_seen_reg) begin
            st1_reg[fdx_pkg::ST1_ABSENT_ID] <= 1'b1;
            st0_reg[7:6] <= fdx_pkg::TERM_ABNORMAL;
            state_reg <= fdx_pkg::S_RES;
          end else if (FLD_DATA_END_I) begin
            sec_cnt_reg <= sec_cnt_reg + 8'h01;
            if (sec_cnt_reg + 8'h01 == eot_reg || xfer_end_reg) begin
              state_reg <= fdx_pkg::S_RES;
            end
          end
        end
        fdx_pkg::S_RES: begin
          st0_reg[2:0] <= (res_idx_reg == 3'h0 && res_last_reg != 3'h0) ?
            {HEAD_SEL_O, DRIVE_SEL_O} : st0_reg[2:0];
          if (rd_start && AVS_ADDRESS_I == fdx_pkg::OFS_RESULT) begin
            res_idx_reg <= res_idx_reg + 3'h1;
            if (res_idx_reg == res_last_reg) begin
              res_idx_reg <= 3'h0;
              WR_DELETED_MARK_O <= 1'b0;
              state_reg <= fdx_pkg::S_IDLE;
            end
          end
        end
        default: state_reg <= fdx_pkg::S_IDLE;
      endcase
    end
  end

endmodule

/* bench/fdx_cmd_exec_asserts.sv */
`timescale 1ns/1ps
// port checks
module fdx_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic IRQ_O,
  input wire logic FLD_ID_VALID_I,
  input wire logic WR_REQ_I,
  input wire logic WR_START_O,
  input wire logic WR_DELETED_MARK_O,
  input wire logic WR_BYTE_VALID_O
);
  logic id_seen_reg;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////
  // id seen since write start
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I || WR_START_O) begin
      id_seen_reg <= 1'b0;
    end else if (FLD_ID_VALID_I) begin
      id_seen_reg <= 1'b1;
    end
  end
  ////////////////////////////////////////
  // bus and write path
  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  property p_ans;
    s_req |=> s_ans;
  endproperty
  property p_idle;
    !(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  property p_rdst;
    !AVS_READ_I |=> $stable(AVS_READDATA_O);
  endproperty
  property p_rst;
    disable iff (1'b0)
    !RST_N_I |=> AVS_WAITREQUEST_O && !IRQ_O && !WR_START_O;
  endproperty
  property p_del;
    WR_START_O |-> WR_DELETED_MARK_O;
  endproperty
  property p_id;
    WR_START_O |-> id_seen_reg;
  endproperty
  property p_byte;
    WR_BYTE_VALID_O |-> $past(WR_REQ_I, 2);
  endproperty
  property p_pulse;
    WR_START_O |=> !WR_START_O [*4];
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  a_idle: assert property (p_idle) else $error("stray answer");
  a_rdst: assert property (p_rdst) else $error("read data moved");
  a_rst: assert property (p_rst) else $error("bad reset");
  a_del: assert property (p_del) else $error("no deleted mark");
  a_id: assert property (p_id) else $error("start without id");
  a_byte: assert property (p_byte) else $error("byte without req");
  a_pulse: assert property (p_pulse) else $error("long start");
endmodule

bind fdx_cmd_exec fdx_chk u_chk (.*);

/* bench/fdx_disk_model.sv */
`timescale 1ns/1ps
// disk side model
module fdx_disk #(
  parameter int GAP = 3
) (
  input wire logic clk_i,
  input wire logic wr_start_i,
  input wire logic wr_v_i,
  input wire logic [7:0] wr_b_i,
  output logic idx_o,
  output logic id_v_o,
  output logic [7:0] t_o,
  output logic [7:0] h_o,
  output logic [7:0] r_o,
  output logic [7:0] n_o,
  output logic crc_o,
  output logic mk_v_o,
  output logic mk_del_o,
  output logic b_v_o,
  output logic [7:0] b_o,
  output logic end_o,
  output logic req_o
);
  int starts = 0;
  int wcnt = 0;
  logic [7:0] wbuf [256];
  initial begin
    {idx_o, id_v_o, crc_o, mk_v_o, mk_del_o, b_v_o, end_o, req_o} = 8'h00;
    {t_o, h_o, r_o, n_o, b_o} = '0;
  end
  ////////////////////////////////////////
  // capture of what the controller writes
  always @(posedge clk_i) begin
    if (wr_start_i) starts++;
    if (wr_v_i) begin
      wbuf[wcnt[7:0]] = wr_b_i;
      wcnt++;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task index();
    idx_o <= 1'b1;
    tick(4);
    idx_o <= 1'b0;
    tick(8);
  endtask
  // id of track 5, head 0, size 0; then scrambled
  task id(input logic [7:0] r, input logic e);
    {t_o, h_o, r_o, n_o, crc_o} <= {8'h05, 8'h00, r, 8'h00, e};
    id_v_o <= 1'b1;
    tick(1);
    id_v_o <= 1'b0;
    {t_o, h_o, r_o, n_o, crc_o} <= ~{8'h05, 8'h00, r, 8'h00, e};
    tick(GAP);
  endtask
  task mark(input logic d);
    mk_del_o <= d;
    mk_v_o <= 1'b1;
    tick(1);
    mk_v_o <= 1'b0;
    mk_del_o <= ~d;
    tick(GAP);
  endtask
  task dbyte(input logic [7:0] v);
    b_o <= v;
    b_v_o <= 1'b1;
    tick(1);
    b_v_o <= 1'b0;
    b_o <= ~v;
    tick(GAP);
  endtask
  task fend();
    end_o <= 1'b1;
    tick(1);
    end_o <= 1'b0;
    tick(GAP);
  endtask
  task req();
    req_o <= 1'b1;
    tick(1);
    req_o <= 1'b0;
    tick(GAP);
  endtask
endmodule

/* bench/test_fdx_cmd_exec.sv */
`timescale 1ns/1ps
// command block bench
module test_fdx_cmd_exec;
  logic CLK_SYS_I, RST_N_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
  logic IRQ_O, INDEX_I, FLD_ID_VALID_I, FLD_ID_CRC_ERR_I, FLD_MARK_VALID_I;
  logic FLD_MARK_DELETED_I, FLD_BYTE_VALID_I, FLD_DATA_END_I, WR_REQ_I;
  logic WR_START_O, WR_DELETED_MARK_O, WR_BYTE_VALID_O, HEAD_SEL_O, DENSITY_O;
  logic [1:0] DRIVE_SEL_O;
  logic [4:0] AVS_ADDRESS_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
  logic [7:0] FLD_ID_TRACK_I, FLD_ID_HEAD_I, FLD_ID_SECTOR_I, FLD_ID_SIZE_I;
  logic [7:0] FLD_BYTE_I, WR_BYTE_O;
  int error_cnt = 0;
  int num_checks = 0;
  fdx_cmd_exec u_dut (.*);
  fdx_disk u_disk (.clk_i(CLK_SYS_I), .wr_start_i(WR_START_O),
    .wr_v_i(WR_BYTE_VALID_O), .wr_b_i(WR_BYTE_O), .idx_o(INDEX_I),
    .id_v_o(FLD_ID_VALID_I), .t_o(FLD_ID_TRACK_I), .h_o(FLD_ID_HEAD_I),
    .r_o(FLD_ID_SECTOR_I), .n_o(FLD_ID_SIZE_I), .crc_o(FLD_ID_CRC_ERR_I),
    .mk_v_o(FLD_MARK_VALID_I), .mk_del_o(FLD_MARK_DELETED_I),
    .b_v_o(FLD_BYTE_VALID_I), .b_o(FLD_BYTE_I), .end_o(FLD_DATA_END_I),
    .req_o(WR_REQ_I));
  ////////////////////////////////////////
  // clock and watchdog
  initial begin
    CLK_SYS_I = 1'b0;
    forever #12.5 CLK_SYS_I = ~CLK_SYS_I;
  end
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end
  task complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest low
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d,
           output logic [7:0] q);
    int n;
    n = 0;
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= {24'h000000, d};
    AVS_WRITE_I <= w;
    AVS_READ_I <= !w;
    @(posedge CLK_SYS_I);
    while (AVS_WAITREQUEST_O !== 1'b0 && n < 50) begin
      n++;
      @(posedge CLK_SYS_I);
    end
    if (n == 50) chk(8'hEE, 8'h00);
    q = AVS_READDATA_O[7:0];
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // drive 1, head 0, track 5, size 0
  task cmd(input logic [7:0] op, r, last_sector_number);
    logic [7:0] b [9];
    b = '{op, 8'h01, 8'h05, 8'h00, r, 8'h00, last_sector_number, 8'h1B, 8'hFF};
    foreach (b[i]) wr(fdx_pkg::OFS_CMD, b[i]);
  endtask
  // poll for result phase, pop seven bytes
  task res(input logic [7:0] e [7]);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while (q[fdx_pkg::MS_DIO] !== 1'b1 && n < 1000) begin
      bus(1'b0, fdx_pkg::OFS_MAIN_STAT, 8'h00, q);
      n++;
    end
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, fdx_pkg::OFS_RESULT, 8'h00, q);
      chk(q, e[i]);
    end
  endtask
  task field(input logic [7:0] s, input int first);
    for (int i = first; i < 128; i++) begin
      u_disk.dbyte(8'(i) ^ s);
      rchk(fdx_pkg::OFS_DATA, 8'(i) ^ s);
    end
    u_disk.fend();
  endtask
  ////////////////////////////////////////
  // scenarios
  task t_bad_op();
    wr(fdx_pkg::OFS_CMD, 8'h1F);
    u_disk.tick(4);
    rchk(fdx_pkg::OFS_RESULT, fdx_pkg::ST0_INVALID);
    rchk(fdx_pkg::OFS_RESULT, 8'h00);
    rchk(5'h1C, 8'h00);
  endtask
  task t_rd_del();
    wr(fdx_pkg::OFS_IRQ_MASK, 8'h02);
    cmd(8'h4C, 8'h03, 8'h07);
    chk(8'(DENSITY_O), 8'h01);
    chk(8'(DRIVE_SEL_O), 8'h01);
    u_disk.id(8'h03, 1'b0);
    u_disk.mark(1'b0);
    u_disk.dbyte(8'h33);
    chk(8'(IRQ_O), 8'h01);
    wr(fdx_pkg::OFS_IRQ_MASK, 8'h00);
    u_disk.tick(2);
    chk(8'(IRQ_O), 8'h00);
    wr(fdx_pkg::OFS_IRQ_STAT, 8'h02);
    rchk(fdx_pkg::OFS_IRQ_STAT, 8'h00);
    rchk(fdx_pkg::OFS_DATA, 8'h33);
    field(8'h33, 1);
    res('{8'h01, 8'h00, 8'h40, 8'h05, 8'h00, 8'h03, 8'h00});
  endtask
  task t_skip();
    cmd(8'h6C, 8'h03, 8'h04);
    wr(fdx_pkg::OFS_IRQ_STAT, 8'h02);
    u_disk.id(8'h03, 1'b0);
    u_disk.mark(1'b0);
    repeat (128) u_disk.dbyte(8'hEE);
    u_disk.fend();
    rchk(fdx_pkg::OFS_IRQ_STAT, 8'h00);
    u_disk.id(8'h04, 1'b0);
    u_disk.mark(1'b1);
    field(8'h5C, 0);
    res('{8'h41, 8'h80, 8'h00, 8'h06, 8'h00, 8'h01, 8'h00});
  endtask
  task t_trk();
    cmd(8'h42, 8'h01, 8'h02);
    wr(fdx_pkg::OFS_IRQ_STAT, 8'h02);
    u_disk.id(8'h01, 1'b0);
    u_disk.mark(1'b0);
    repeat (8) u_disk.dbyte(8'hEE);
    rchk(fdx_pkg::OFS_IRQ_STAT, 8'h00);
    u_disk.index();
    u_disk.id(8'h01, 1'b1);
    u_disk.mark(1'b0);
    field(8'h11, 0);
    u_disk.id(8'h09, 1'b0);
    u_disk.mark(1'b0);
    field(8'h22, 0);
    chk(8'(HEAD_SEL_O), 8'h00);
    res('{8'h01, 8'h04, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00});
  endtask
  task t_no_id();
    cmd(8'h02, 8'h01, 8'h02);
    u_disk.index();
    u_disk.tick(50);
    u_disk.index();
    res('{8'h41, 8'h01, 8'h00, 8'h05, 8'h00, 8'h01, 8'h00});
  endtask
  task t_wr_tc();
    cmd(8'h49, 8'h03, 8'h03);
    chk(8'(WR_DELETED_MARK_O), 8'h01);
    u_disk.id(8'h02, 1'b0);
    u_disk.tick(10);
    chk(8'(u_disk.starts), 8'h00);
    u_disk.id(8'h03, 1'b0);
    u_disk.tick(4);
    chk(8'(u_disk.starts), 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(fdx_pkg::OFS_DATA, 8'hC0 + 8'(i));
      u_disk.req();
    end
    wr(fdx_pkg::OFS_CONTROL, 8'h01);
    repeat (124) u_disk.req();
    for (int i = 0; i < 4; i++) chk(u_disk.wbuf[i], 8'hC0 + 8'(i));
    for (int i = 4; i < 128; i++) chk(u_disk.wbuf[i], 8'h00);
    chk(8'(u_disk.wcnt), 8'h80);
    res('{8'h01, 8'h00, 8'h00, 8'h05, 8'h00, 8'h03, 8'h00});
  endtask
  task t_ovr();
    cmd(8'h09, 8'h03, 8'h03);
    u_disk.id(8'h03, 1'b0);
    wr(fdx_pkg::OFS_DATA, 8'h5A);
    u_disk.req();
    u_disk.req();
    res('{8'h41, 8'h10, 8'h00, 8'h05, 8'h00, 8'h03, 8'h00});
  endtask
  // reset, then the scenarios in turn
  initial begin
    RST_N_I = 1'b0;
    {AVS_READ_I, AVS_WRITE_I, AVS_ADDRESS_I} = 7'h00;
    AVS_WRITEDATA_I = 32'h00000000;
    repeat (12) @(posedge CLK_SYS_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_SYS_I);
    t_bad_op();
    t_rd_del();
    t_skip();
    t_trk();
    t_no_id();
    t_wr_tc();
    t_ovr();
    complete_run();
  end
endmodule
